// >>> verilog/qmr_pkg.sv
// package for the four-lane mode, read parameter and reset controller
// assumes one 200 MHz system clock; all link pins sampled into that domain
package qmr_pkg;

  // command codes
  localparam logic [7:0] CMD_SET_READ_PARAM = 8'hC0;
  localparam logic [7:0] CMD_FAST_READ      = 8'h0B;
  localparam logic [7:0] CMD_QUAD_IO_READ   = 8'hEB;
  localparam logic [7:0] CMD_BURST_WRAP     = 8'h0C;
  localparam logic [7:0] CMD_SET_BURST_WRAP = 8'h77;
  localparam logic [7:0] CMD_ENABLE_FOUR    = 8'h38;
  localparam logic [7:0] CMD_DISABLE_FOUR   = 8'hFF;
  localparam logic [7:0] CMD_RESET_ENABLE   = 8'h66;
  localparam logic [7:0] CMD_RESET          = 8'h99;

  // read parameter byte fields and reset values
  localparam int         DUMMY_FIELD_LSB    = 4;
  localparam int         WRAP_FIELD_LSB     = 0;
  localparam int         SPI_WRAP_FIELD_LSB = 4;
  localparam logic [1:0] DUMMY_FIELD_RESET  = 2'h0;
  localparam logic [1:0] WRAP_FIELD_RESET   = 2'h0;
  localparam logic [7:0] CONT_READ_RESET    = 8'h00;

  // fixed dummy clocks in spi modes
  localparam logic [3:0] SPI_DUMMY_FAST_READ = 4'h8;
  localparam logic [3:0] SPI_DUMMY_QUAD_IO   = 4'h4;
  localparam logic [3:0] SPI_DUMMY_OTHER     = 4'h8;

  // timing
  localparam int RESET_TIME_NS   = 30000;
  localparam int CLK_PERIOD_NS   = 5;
  localparam int RESET_CYCLES    = RESET_TIME_NS / CLK_PERIOD_NS;
  localparam int ADDR_BITS       = 24;

  typedef struct packed {
    logic       cs_n;
    logic       sclk;
    logic [3:0] io;
  } qmr_pins_type;

  typedef struct packed {
    logic [1:0] dummy_code;
    logic [1:0] wrap_code;
  } qmr_read_param_type;

endpackage : qmr_pkg

// >>> verilog/qmr_pin_sync.sv
// two-flop synchroniser for the link pins and sclk edge finder while chip select is low
// assumes the pins are asynchronous to sys_clk
`timescale 1ns/10ps
`default_nettype none
module qmr_pin_sync
  import qmr_pkg::*;
(
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // raw pins
  input  wire qmr_pkg::qmr_pins_type pins_in,
  // synchronised view
  output qmr_pkg::qmr_pins_type      pins_sync,
  output logic              sclk_rise,
  output logic              sclk_fall
);
  qmr_pins_type meta_ff;
  qmr_pins_type sync_ff;
  logic         sclk_prev_ff;

  // first stage is read only by the second
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_ff      <= '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
      sync_ff      <= '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
      sclk_prev_ff <= 1'b0;
    end
    else
    begin
      meta_ff      <= pins_in;
      sync_ff      <= meta_ff;
      sclk_prev_ff <= sync_ff.sclk;
    end
  end

  assign pins_sync = sync_ff;
  assign sclk_rise = sync_ff.sclk & ~sclk_prev_ff & ~sync_ff.cs_n;
  assign sclk_fall = ~sync_ff.sclk & sclk_prev_ff & ~sync_ff.cs_n;
endmodule : qmr_pin_sync
`default_nettype wire

// >>> verilog/qmr_reset_timer.sv
// down counter holding the device in software reset
// assumes a one-cycle start pulse
`timescale 1ns/10ps
`default_nettype none
module qmr_reset_timer
  import qmr_pkg::*;
#(
  parameter int RESET_LEN = RESET_CYCLES
)
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // control
  input  wire logic start,
  output logic      busy
);
  logic [15:0] count_ff;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      count_ff <= 16'h0000;
    else if (start)
      count_ff <= 16'(RESET_LEN);
    else if (count_ff != 16'h0000)
      count_ff <= count_ff - 16'h0001;
  end

  assign busy = (count_ff != 16'h0000);
endmodule : qmr_reset_timer
`default_nettype wire

// >>> verilog/qmr_ctrl.sv
// command interpreter: mode switch, read parameters, wrapping read, reset
// assumes the array lives outside; link pins arrive asynchronously
`timescale 1ns/10ps
`default_nettype none
module qmr_ctrl
  import qmr_pkg::*;
#(
  parameter int RESET_LEN = RESET_CYCLES
)
(
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // link pins
  input  wire qmr_pkg::qmr_pins_type link_pins,
  // state from the rest of the device
  input  wire logic                  quad_enable_bit,
  input  wire logic                  array_busy,
  input  wire logic                  write_enable_set,
  input  wire logic                  write_enable_clr,
  input  wire logic                  suspend_set,
  input  wire logic                  suspend_clr,
  input  wire logic                  cont_read_load,
  input  wire logic [7:0]            cont_read_value,
  // mode and settings
  output logic                       four_lane_command_mode,
  output qmr_pkg::qmr_read_param_type read_params,
  output logic [3:0]                 dummy_clocks,
  output logic [6:0]                 wrap_bytes,
  output logic [2:0]                 wrap_setting_bits,
  output logic [7:0]                 continuous_read_bits,
  output logic                       write_enable_latch,
  output logic                       suspend_flag,
  output logic                       busy_flag,
  // read address stream and reset
  output logic [23:0]                read_addr,
  output logic                       read_addr_valid,
  output logic                       soft_reset_pulse,
  output logic                       reset_busy
);
  typedef enum {ST_CMD, ST_ADDR, ST_PARAM, ST_SPI_WRAP, ST_DUMMY, ST_DATA, ST_IGNORE}
    qmr_state_type;

  qmr_pins_type  pins;
  logic          sclk_rise;
  logic          sclk_fall;
  qmr_state_type state_ff;
  logic [7:0]    shift_ff;
  logic [5:0]    bit_cnt_ff;
  logic [7:0]    cmd_ff;
  logic          reset_armed_ff;
  logic          mode_ff;
  qmr_read_param_type param_ff;
  logic [2:0]    wrap_bits_ff;
  logic [7:0]    cont_ff;
  logic          wel_ff;
  logic          sus_ff;
  logic [23:0]   addr_ff;
  logic          addr_valid_ff;
  logic          start_reset;
  logic          timer_busy;
  logic          cmd_done;
  logic [7:0]    cmd_byte;
  logic [7:0]    nxt_shift;
  logic [3:0]    lane_bits;

  qmr_pin_sync u_sync (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .pins_in   (link_pins),
    .pins_sync (pins),
    .sclk_rise (sclk_rise),
    .sclk_fall ()
  );

  qmr_reset_timer #(.RESET_LEN(RESET_LEN)) u_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (start_reset),
    .busy    (timer_busy)
  );

  function automatic logic [3:0] dummy_of(input logic [1:0] code);
    dummy_of = {1'b0, code, 1'b0} + 4'h2;
  endfunction : dummy_of

  function automatic logic [6:0] wrap_of(input logic [1:0] code);
    wrap_of = 7'h08 << code;
  endfunction : wrap_of

  // four lanes in four-lane mode, one lane otherwise
  assign lane_bits = mode_ff ? 4'h4 : 4'h1;
  assign nxt_shift = mode_ff ? {shift_ff[3:0], pins.io} : {shift_ff[6:0], pins.io[0]};
  assign cmd_byte  = nxt_shift;
  assign cmd_done  = sclk_rise && (state_ff == ST_CMD)
                     && ({2'b00, bit_cnt_ff} + 8'(lane_bits) == 8'h08)
                     && !timer_busy;

  // accepted reset: armed and next command is reset
  assign start_reset = cmd_done && reset_armed_ff && (cmd_byte == CMD_RESET);

  // frame sequencer; a new frame starts at chip-select fall
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff   <= ST_CMD;
      bit_cnt_ff <= 6'h00;
      shift_ff   <= 8'h00;
      cmd_ff     <= 8'h00;
    end
    else
    begin
      if (pins.cs_n || timer_busy)
      begin
        state_ff   <= timer_busy ? ST_IGNORE : ST_CMD;
        bit_cnt_ff <= 6'h00;
        if (!timer_busy)
          state_ff <= ST_CMD;
      end
      else if (sclk_rise)
      begin
        shift_ff   <= nxt_shift;
        bit_cnt_ff <= bit_cnt_ff + 6'(lane_bits);
        unique case (state_ff)
          ST_CMD:
          begin
            if (cmd_done)
            begin
              cmd_ff     <= cmd_byte;
              bit_cnt_ff <= 6'h00;
              unique case (cmd_byte)
                CMD_SET_READ_PARAM: state_ff <= mode_ff ? ST_PARAM : ST_IGNORE;
                CMD_SET_BURST_WRAP: state_ff <= mode_ff ? ST_IGNORE : ST_ADDR;
                CMD_BURST_WRAP:     state_ff <= mode_ff ? ST_ADDR : ST_IGNORE;
                CMD_FAST_READ,
                CMD_QUAD_IO_READ:   state_ff <= ST_ADDR;
                default:            state_ff <= ST_IGNORE;
              endcase
            end
          end
          ST_ADDR:
          begin
            if (bit_cnt_ff + 6'(lane_bits) == 6'(ADDR_BITS))
            begin
              bit_cnt_ff <= 6'h00;
              state_ff   <= (cmd_ff == CMD_SET_BURST_WRAP) ? ST_SPI_WRAP : ST_DUMMY;
            end
          end
          ST_PARAM, ST_SPI_WRAP:
          begin
            if (bit_cnt_ff + 6'(lane_bits) == 6'h08)
              state_ff <= ST_IGNORE;
          end
          ST_DUMMY:
          begin
            if (bit_cnt_ff + 6'(lane_bits) == 6'({dummy_clocks, 2'b00} >> (mode_ff ? 0 : 2)))
              state_ff <= ST_DATA;
          end
          ST_DATA, ST_IGNORE: ;
        endcase
      end
    end
  end

  // mode register
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      mode_ff <= 1'b0;
    else if (start_reset)
      mode_ff <= 1'b0;
    else if (cmd_done && !mode_ff && cmd_byte == CMD_ENABLE_FOUR && quad_enable_bit)
      mode_ff <= 1'b1;
    else if (cmd_done && mode_ff && cmd_byte == CMD_DISABLE_FOUR)
      mode_ff <= 1'b0;
  end

  // reset arming
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      reset_armed_ff <= 1'b0;
    else if (cmd_done)
      reset_armed_ff <= (cmd_byte == CMD_RESET_ENABLE);
  end

  // read parameters and wrap settings; mode changes leave them alone
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      param_ff     <= '{dummy_code: DUMMY_FIELD_RESET, wrap_code: WRAP_FIELD_RESET};
      wrap_bits_ff <= 3'h0;
    end
    else if (start_reset)
    begin
      param_ff     <= '{dummy_code: DUMMY_FIELD_RESET, wrap_code: WRAP_FIELD_RESET};
      wrap_bits_ff <= 3'h0;
    end
    else if (sclk_rise && !pins.cs_n && state_ff == ST_PARAM
             && bit_cnt_ff + 6'(lane_bits) == 6'h08)
    begin
      param_ff.dummy_code <= nxt_shift[DUMMY_FIELD_LSB +: 2];
      param_ff.wrap_code  <= nxt_shift[WRAP_FIELD_LSB +: 2];
    end
    else if (sclk_rise && !pins.cs_n && state_ff == ST_SPI_WRAP
             && bit_cnt_ff + 6'(lane_bits) == 6'h08)
    begin
      wrap_bits_ff       <= nxt_shift[SPI_WRAP_FIELD_LSB +: 3];
      param_ff.wrap_code <= nxt_shift[SPI_WRAP_FIELD_LSB +: 2];
    end
  end

  // write latch, suspend and continuous-read bits survive mode changes
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wel_ff  <= 1'b0;
      sus_ff  <= 1'b0;
      cont_ff <= CONT_READ_RESET;
    end
    else if (start_reset)
    begin
      wel_ff  <= 1'b0;
      sus_ff  <= 1'b0;
      cont_ff <= CONT_READ_RESET;
    end
    else
    begin
      // set wins over clear
      if (write_enable_set)
        wel_ff <= 1'b1;
      else if (write_enable_clr)
        wel_ff <= 1'b0;
      if (suspend_set)
        sus_ff <= 1'b1;
      else if (suspend_clr)
        sus_ff <= 1'b0;
      if (cont_read_load)
        cont_ff <= cont_read_value;
    end
  end

  // read address counter with wrap in the aligned block
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      addr_ff       <= 24'h000000;
      addr_valid_ff <= 1'b0;
    end
    else if (pins.cs_n || start_reset)
      addr_valid_ff <= 1'b0;
    else if (sclk_rise && state_ff == ST_ADDR)
      addr_ff <= mode_ff ? {addr_ff[19:0], pins.io} : {addr_ff[22:0], pins.io[0]};
    else if (sclk_rise && state_ff == ST_DATA && cmd_ff != CMD_SET_BURST_WRAP)
    begin
      addr_valid_ff <= 1'b1;
      if (addr_valid_ff && bit_cnt_ff[2:0] == 3'h0)
      begin
        if (cmd_ff == CMD_BURST_WRAP)
          addr_ff <= (addr_ff & ~24'(wrap_bytes - 7'h01))
                     | ((addr_ff + 24'h000001) & 24'(wrap_bytes - 7'h01));
        else
          addr_ff <= addr_ff + 24'h000001;
      end
    end
  end

  // dummy clocks: programmable in four-lane mode, fixed in spi mode
  always_comb
  begin
    if (mode_ff)
      dummy_clocks = dummy_of(param_ff.dummy_code);
    else if (cmd_ff == CMD_QUAD_IO_READ)
      dummy_clocks = SPI_DUMMY_QUAD_IO;
    else if (cmd_ff == CMD_FAST_READ)
      dummy_clocks = SPI_DUMMY_FAST_READ;
    else
      dummy_clocks = SPI_DUMMY_OTHER;
  end

  assign four_lane_command_mode = mode_ff;
  assign read_params            = param_ff;
  assign wrap_bytes             = wrap_of(param_ff.wrap_code);
  assign wrap_setting_bits      = wrap_bits_ff;
  assign continuous_read_bits   = cont_ff;
  assign write_enable_latch     = wel_ff;
  assign suspend_flag           = sus_ff;
  assign busy_flag              = array_busy | timer_busy;
  assign read_addr              = addr_ff;
  assign read_addr_valid        = addr_valid_ff;
  assign soft_reset_pulse       = start_reset;
  assign reset_busy             = timer_busy;
endmodule : qmr_ctrl
`default_nettype wire

// >>> test/qmr_host_model.sv
// host model: drives chip select, link clock and lanes of the command link
// assumes the link clock stands still between frames and a 48 ns clock period
`timescale 1ns/10ps
`default_nettype none
module qmr_host_model
  import qmr_pkg::*;
(
  // link pins
  output var qmr_pkg::qmr_pins_type pins
);
  initial pins = {1'b1, 1'b0, 4'hF};

  // bytes msb first; four-lane sends the high nibble first
  task automatic send(input logic four, input logic [39:0] d, input int nbytes, input int extra);
    int nbits;
    nbits = nbytes * 8;
    pins.cs_n = 1'b0;
    #24;
    for (int i = 0; i < nbits; i += (four ? 4 : 1))
    begin
      if (four)
        pins.io = d[39 - i -: 4];
      else
        pins.io = {3'b111, d[39 - i]};
      #24 pins.sclk = 1'b1;
      #24 pins.sclk = 1'b0;
    end
    // lanes handed over: no pull, so show the inverse rather than a stale level
    pins.io = ~pins.io;
    repeat (extra)
    begin
      #24 pins.sclk = 1'b1;
      #24 pins.sclk = 1'b0;
    end
    #24 pins.cs_n = 1'b1;
    pins.io = ~pins.io;
    #96;
  endtask : send
endmodule : qmr_host_model
`default_nettype wire

// >>> test/qmr_ctrl_checker.sv
// assertions on the command interpreter ports
// assumes one sys_clk domain and async active-high rst
`timescale 1ns/10ps
`default_nettype none
module qmr_ctrl_checker
  import qmr_pkg::*;
#(
  parameter int RESET_LEN = 20
)
(
  // clock and reset
  input wire logic                        sys_clk,
  input wire logic                        rst,
  // device inputs
  input wire logic                        quad_enable_bit,
  input wire logic                        array_busy,
  // mode and settings
  input wire logic                        four_lane_command_mode,
  input wire qmr_pkg::qmr_read_param_type read_params,
  input wire logic [3:0]                  dummy_clocks,
  input wire logic [6:0]                  wrap_bytes,
  input wire logic [2:0]                  wrap_setting_bits,
  input wire logic [7:0]                  continuous_read_bits,
  input wire logic                        write_enable_latch,
  input wire logic                        suspend_flag,
  input wire logic                        busy_flag,
  input wire logic                        soft_reset_pulse,
  input wire logic                        reset_busy
);
  int unsigned busy_cnt_ff;

  // a counter, since the busy window is far longer than a repetition may be
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      busy_cnt_ff <= 0;
    else
      busy_cnt_ff <= reset_busy ? busy_cnt_ff + 1 : 0;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_reset_start;
    soft_reset_pulse ##1 (reset_busy && !soft_reset_pulse);
  endsequence

  sequence s_power_on;
    !four_lane_command_mode && read_params == '0 && wrap_setting_bits == '0
      && continuous_read_bits == '0 && !write_enable_latch && !suspend_flag;
  endsequence

  a_reset_starts: assert property (soft_reset_pulse |-> s_reset_start)
    else $error("reset pulse did not start busy");
  a_reset_length: assert property ($fell(reset_busy) |-> busy_cnt_ff == RESET_LEN)
    else $error("reset busy length wrong");
  a_reset_clears: assert property (soft_reset_pulse |-> ##[1:2] s_power_on)
    else $error("reset left state behind");
  a_busy_frozen: assert property (reset_busy && $past(reset_busy)
    |=> $stable(four_lane_command_mode) && $stable(read_params))
    else $error("command taken during reset");
  a_dummy_map: assert property (four_lane_command_mode
    |-> dummy_clocks == {1'b0, read_params.dummy_code, 1'b0} + 4'h2)
    else $error("dummy count wrong");
  a_wrap_map: assert property (four_lane_command_mode
    |-> wrap_bytes == (7'h08 << read_params.wrap_code))
    else $error("wrap length wrong");
  a_busy_sum: assert property (busy_flag == (array_busy | reset_busy))
    else $error("busy flag wrong");
  a_enter_needs_qe: assert property ($rose(four_lane_command_mode) |-> quad_enable_bit)
    else $error("entered four-lane without quad enable");
  a_switch_keeps: assert property ($changed(four_lane_command_mode) && !reset_busy
    && !soft_reset_pulse && !$past(soft_reset_pulse) |-> $stable(write_enable_latch)
    && $stable(suspend_flag) && $stable(wrap_bytes))
    else $error("mode change lost state");
  a_spi_param_hold: assert property (!four_lane_command_mode && !soft_reset_pulse
    && !reset_busy |=> $stable(read_params.dummy_code))
    else $error("dummy count changed in spi mode");
endmodule : qmr_ctrl_checker

bind qmr_ctrl qmr_ctrl_checker #(.RESET_LEN(RESET_LEN)) i_qmr_ctrl_checker (
  .sys_clk, .rst, .quad_enable_bit, .array_busy, .four_lane_command_mode, .read_params,
  .dummy_clocks, .wrap_bytes, .wrap_setting_bits, .continuous_read_bits, .write_enable_latch,
  .suspend_flag, .busy_flag, .soft_reset_pulse, .reset_busy
);
`default_nettype wire

// >>> test/qmr_ctrl_tb.sv
// self-checking bench for the command interpreter
// assumes the host model drives the link; short reset window for simulation
`timescale 1ns/10ps
`default_nettype none
module qmr_ctrl_tb;
  import qmr_pkg::*;
  localparam int RLEN = 200;
  logic sys_clk, rst, quad_enable_bit, array_busy, write_enable_set, suspend_set;
  logic cont_read_load, four_lane_command_mode, write_enable_latch, suspend_flag, busy_flag;
  logic read_addr_valid, soft_reset_pulse, reset_busy, pulse_seen, addr_wrapped, addr_out;
  logic [7:0]         cont_read_value, continuous_read_bits;
  logic [3:0]         dummy_clocks;
  logic [6:0]         wrap_bytes;
  logic [2:0]         wrap_setting_bits;
  logic [23:0]        read_addr;
  qmr_read_param_type read_params;
  qmr_pins_type       link_pins;
  int                 failures;
  int                 checked;

  qmr_host_model i_qmr_host_model (.pins(link_pins));
  qmr_ctrl #(.RESET_LEN(RLEN)) i_qmr_ctrl (
    .sys_clk, .rst, .link_pins, .quad_enable_bit, .array_busy, .write_enable_set,
    .write_enable_clr(1'b0), .suspend_set, .suspend_clr(1'b0), .cont_read_load,
    .cont_read_value, .four_lane_command_mode, .read_params, .dummy_clocks, .wrap_bytes,
    .wrap_setting_bits, .continuous_read_bits, .write_enable_latch, .suspend_flag,
    .busy_flag, .read_addr, .read_addr_valid, .soft_reset_pulse, .reset_busy
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    if (soft_reset_pulse === 1'b1)
      pulse_seen <= 1'b1;
    if (read_addr_valid === 1'b1 && read_addr === 24'h0)
      addr_wrapped <= 1'b1;
    if (read_addr_valid === 1'b1 && read_addr[23:6] !== 18'h0)
      addr_out <= 1'b1;
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one frame, then the three-cycle answer latency plus margin
  task automatic frame(input logic four, input logic [39:0] d, input int n, input int extra);
    i_qmr_host_model.send(four, d, n, extra);
    repeat (4) @(negedge sys_clk);
  endtask : frame

  task automatic print_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  initial
  begin
    {rst, quad_enable_bit, array_busy, write_enable_set, suspend_set} = 5'b10000;
    {cont_read_load, cont_read_value, pulse_seen, addr_wrapped, addr_out} = '0;
    failures = 0;
    checked = 0;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    check("mode", 8'h0, four_lane_command_mode);
    check("params", 8'h0, read_params);
    check("wrap", 8'h08, wrap_bytes);
    frame(0, {CMD_SET_READ_PARAM, 8'h33, 24'h0}, 2, 0);
    check("spi params", 8'h0, read_params);
    frame(0, {CMD_ENABLE_FOUR, 32'h0}, 1, 0);
    check("mode no qe", 8'h0, four_lane_command_mode);
    {write_enable_set, suspend_set, cont_read_load, array_busy} = 4'hF;
    cont_read_value = 8'hA5;
    @(negedge sys_clk);
    {write_enable_set, suspend_set, cont_read_load} = 3'h0;
    check("busy", 8'h1, busy_flag);
    array_busy = 1'b0;
    frame(0, {CMD_SET_BURST_WRAP, 24'h0, 8'h20}, 5, 0);
    check("spi wrap", 8'h20, wrap_bytes);
    check("wrap bits", 8'h02, wrap_setting_bits);
    quad_enable_bit = 1'b1;
    frame(0, {CMD_ENABLE_FOUR, 32'h0}, 1, 0);
    check("mode", 8'h1, four_lane_command_mode);
    check("latch", 8'h1, write_enable_latch);
    check("suspend", 8'h1, suspend_flag);
    check("wrap kept", 8'h20, wrap_bytes);
    for (int i = 0; i < 4; i++)
    begin
      frame(1, {CMD_SET_READ_PARAM, 2'b00, 2'(3 - i), 2'b00, 2'(i), 24'h0}, 2, 0);
      check("dummy", 8'(8 - 2 * i), dummy_clocks);
      check("wrap len", 8'(8 << i), wrap_bytes);
    end
    frame(1, {CMD_BURST_WRAP, 24'h00003E, 8'h0}, 4, 12);
    check("wrapped", 8'h1, addr_wrapped);
    check("in block", 8'h0, addr_out);
    frame(1, {CMD_DISABLE_FOUR, 32'h0}, 1, 0);
    check("mode", 8'h0, four_lane_command_mode);
    check("latch", 8'h1, write_enable_latch);
    check("wrap", 8'h40, wrap_bytes);
    frame(0, {CMD_RESET_ENABLE, 32'h0}, 1, 0);
    frame(0, {CMD_FAST_READ, 32'h0}, 4, 0);
    check("spi dummy", 8'(SPI_DUMMY_FAST_READ), dummy_clocks);
    check("cont loaded", 8'hA5, continuous_read_bits);
    frame(0, {CMD_RESET, 32'h0}, 1, 0);
    check("no reset", 8'h0, pulse_seen);
    frame(0, {CMD_ENABLE_FOUR, 32'h0}, 1, 0);
    check("busy first", 8'h0, busy_flag);
    frame(1, {CMD_RESET_ENABLE, 32'h0}, 1, 0);
    frame(1, {CMD_RESET, 32'h0}, 1, 0);
    check("reset", 8'h1, pulse_seen);
    check("busy", 8'h1, busy_flag);
    check("mode", 8'h0, four_lane_command_mode);
    check("latch", 8'h0, write_enable_latch);
    check("suspend", 8'h0, suspend_flag);
    check("cont", 8'h0, continuous_read_bits);
    check("wrap bits", 8'h0, wrap_setting_bits);
    check("params", 8'h0, read_params);
    check("wrap", 8'h08, wrap_bytes);
    frame(0, {CMD_ENABLE_FOUR, 32'h0}, 1, 0);
    check("refused", 8'h0, four_lane_command_mode);
    for (int n = 0; n < 400 && reset_busy !== 1'b0; n++)
      @(negedge sys_clk);
    check("reset done", 8'h0, reset_busy);
    frame(0, {CMD_ENABLE_FOUR, 32'h0}, 1, 0);
    check("mode", 8'h1, four_lane_command_mode);
    print_verdict();
  end
endmodule : qmr_ctrl_tb
`default_nettype wire
